// ==== swc_regs.svh ====
/*
 * register offsets, field positions, reset values and timing counts for the
 * watchdog, can channel 0 and internal wake configuration bank.
 * assumes it is included by bare name wherever these constants are needed.
 */
`ifndef SWC_REGS_SVH
`define SWC_REGS_SVH

`define SWC_ADDR_WDOG        7'h03
`define SWC_ADDR_CAN_CH0_MODE_FIELD        7'h04
`define SWC_ADDR_IWAKE       7'h06

`define SWC_WDOG_RESET       8'h14
`define SWC_CAN_CH0_MODE_FIELD_RESET       8'h00
`define SWC_IWAKE_RESET      8'h01

`define SWC_WDOG_WMASK       8'hff
`define SWC_CAN_CH0_MODE_FIELD_WMASK       8'h07
`define SWC_IWAKE_WMASK      8'h75
`define SWC_IWAKE_RST_KEEP   8'h71

`define SWC_WD_CHECKSUM      7
`define SWC_WD_STOP_OFF      6
`define SWC_WD_WINDOW        5
`define SWC_WD_BUS_START     4
`define SWC_WD_MAX3          3
`define SWC_WD_PER_HI        2
`define SWC_WD_PER_RESTART   3'h4
`define SWC_WD_PER_UNDEF     3'h6

`define SWC_CAN_SELWAKE      2
`define SWC_CAN_WAKE_LOW     2'h1

`define SWC_IW_CYCLIC        6
`define SWC_IW_THR_HI        5
`define SWC_IW_THR_LO        4
`define SWC_IW_STOP_OFF      2
`define SWC_IW_FAST_BATT     0

`define SWC_MAX_WDOG_RESETS  2'h3
`define SWC_FRAME_BITS       5'h10

`endif

// ==== swc_pkg.sv ====
/*
 * types shared by the configuration bank and its serial slave.
 * assumes swc_regs.svh is available on the include path.
 */
package swc_pkg;

	typedef enum logic [1:0] {
		CAN_OFF      = 2'b00,
		CAN_WAKE     = 2'b01,
		CAN_RX_ONLY  = 2'b10,
		CAN_NORMAL   = 2'b11
	} swc_can_mode_t;

	typedef struct packed {
		logic          checksum_ok;
		logic          window_type_select;
		logic          bus_wake_wdog_start;
		logic          limit_resets;
		logic [2:0]    wdog_period_sel;
		logic          period_defined;
		logic [9:0]    period_ms;
		logic          stop_wdog_off;
	} swc_wdog_cfg_t;

	typedef struct packed {
		swc_can_mode_t can_ch0_mode_field;
		logic          selective_wake;
		logic          cyclic_wake_enable;
		logic [1:0]    batt_monitor_threshold;
		logic          fast_batt_monitor_enable;
	} swc_wake_cfg_t;

	typedef struct packed {
		logic          write;
		logic [6:0]    addr;
		logic [7:0]    data;
	} swc_frame_t;

endpackage

// ==== swc_spi_slave.sv ====
/*
 * 16-bit serial slave: write flag, 7-bit address, 8-bit data, msb first.
 * assumes spi pins come from outside the clock domain and sclk is far slower
 * than clk_in; the addressed register value is returned in the second byte.
 */
`timescale 1ns/10ps
`include "swc_regs.svh"

module swc_spi_slave
	import swc_pkg::*;
(
	input  wire logic       clk_in,
	input  wire logic       resetn_in,
	input  wire logic       ce_in,
	input  wire logic       sclk_in,
	input  wire logic       csn_in,
	input  wire logic       mosi_in,
	output logic            miso_out,
	output logic            miso_oe_out,
	output logic [6:0]      addr_out,
	input  wire logic [7:0] rdata_in,
	output logic            frame_valid_out,
	output swc_frame_t      frame_out
);

	logic [2:0]  sclk_s_r;
	logic [2:0]  csn_s_r;
	logic [1:0]  mosi_s_r;
	logic [15:0] shift_r;
	logic [4:0]  count_r;
	logic [7:0]  tx_r;
	logic        miso_r;
	logic        valid_r;
	swc_frame_t  frame_r;

	wire sclk_rise = sclk_s_r[1] & ~sclk_s_r[2];
	wire sclk_fall = ~sclk_s_r[1] & sclk_s_r[2];
	wire sel       = ~csn_s_r[1];
	wire csn_rise  = csn_s_r[1] & ~csn_s_r[2];
	wire load_tx   = sel & sclk_fall & (count_r == 5'h08);
	wire full      = (count_r == `SWC_FRAME_BITS);

	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			sclk_s_r <= 3'h0;
			csn_s_r  <= 3'h7;
			mosi_s_r <= 2'h0;
			shift_r  <= 16'h0000;
			count_r  <= 5'h00;
			tx_r     <= 8'h00;
			miso_r   <= 1'b0;
			valid_r  <= 1'b0;
			frame_r  <= '0;
		end else if (ce_in) begin
			sclk_s_r <= {sclk_s_r[1:0], sclk_in};
			csn_s_r  <= {csn_s_r[1:0], csn_in};
			mosi_s_r <= {mosi_s_r[0], mosi_in};
			valid_r  <= csn_rise & full;
			if (csn_rise & full)
				frame_r <= shift_r;
			if (!sel)
				count_r <= 5'h00;
			else if (sclk_rise && !full) begin
				shift_r <= {shift_r[14:0], mosi_s_r[1]};
				count_r <= count_r + 5'h01;
			end
			// first byte answers zero, second byte the addressed register
			if (!sel)
				miso_r <= 1'b0;
			else if (load_tx) begin
				miso_r <= rdata_in[7];
				tx_r   <= {rdata_in[6:0], 1'b0};
			end else if (sclk_fall && count_r > 5'h08) begin
				miso_r <= tx_r[7];
				tx_r   <= {tx_r[6:0], 1'b0};
			end
		end
	end

	assign addr_out        = shift_r[6:0];
	assign miso_out        = miso_r;
	assign miso_oe_out     = sel;
	assign frame_valid_out = valid_r;
	assign frame_out       = frame_r;

endmodule // swc_spi_slave

// ==== swc_config_bank.sv ====
/*
 * watchdog, can channel 0 mode and internal wake configuration registers,
 * written and read over the serial slave, with the automatic updates made
 * on restart, fail-safe and sleep entry; stop entry changes nothing.
 * assumes mode event inputs are one-cycle pulses from logic on clk_in.
 */
`timescale 1ns/10ps
`include "swc_regs.svh"

// How it works
// - watchdog config bit 6 and internal wake bit 2 both set deactivate watchdog in stop mode
// - watchdog config bit 5 picks time-out (0) or window (1) watchdog
// - bit 4 set starts watchdog with long open window on stop bus wake
// - bit 3 stops resets after three consecutive fails, configs 1/3
// - period field decodes 10 to 1000 ms; code 110 undefined
// - watchdog config loads 0001 0100 at power-on or soft reset
// - restart clears stop-off bit and sets period code 100 (200 ms), others kept
// - can mode field: off, wake, receive only, normal, with selective wake
// - device touches selective wake bit only on soft reset (clears it), otherwise only lower two bits
// - sleep entry without system error turns x11 into wake capable x01
// - x10 goes wake capable on sleep, stays receive only on stop
// - wake capable or off channel keeps its mode on sleep or stop
// - fail-safe entry rewrites bus config so later wake stays possible
// - bus config resets to zero; restart keeps the can mode bits and the selective wake bit
// - internal wake bit 6 enables cyclic timer wake
// - internal wake bits 5:4 select one of four battery thresholds
// - internal wake bit 2 is second watchdog stop-off bit
// - internal wake bit 0 enables fast battery monitoring
// - internal wake loads 0000 0001; restart clears bits 7, 3, 2, 1
// - reserved bits always read back as zero
module swc_config_bank
	import swc_pkg::*;
(
	input  wire logic clk_in,
	input  wire logic resetn_in,
	input  wire logic ce_in,
	input  wire logic sclk_in,
	input  wire logic csn_in,
	input  wire logic mosi_in,
	output logic      miso_out,
	output logic      miso_oe_out,
	input  wire logic soft_reset_in,
	input  wire logic restart_entry_in,
	input  wire logic failsafe_entry_in,
	input  wire logic sleep_entry_in,
	input  wire logic stop_entry_in,
	input  wire logic stop_mode_in,
	input  wire logic ch0_system_error_flag_in,
	input  wire logic can_bus_wake_in,
	input  wire logic wdog_fail_in,
	input  wire logic wdog_trigger_ok_in,
	input  wire logic config_1_3_in,
	output logic      wdog_reset_req_out,
	output logic      wdog_long_window_start_out,
	output swc_wdog_cfg_t wdog_cfg_out,
	output swc_wake_cfg_t wake_cfg_out
);

	logic [7:0]  wdog_r;
	logic [7:0]  wdog_nxt;
	logic [7:0]  can_r;
	logic [7:0]  can_nxt;
	logic [7:0]  iwake_r;
	logic [7:0]  iwake_nxt;
	logic [1:0]  fail_cnt_r;
	logic        reset_req_r;
	logic        long_start_r;
	logic [9:0]  period_ms;
	logic [7:0]  rd_data;
	logic [6:0]  rd_addr;
	logic        frame_valid;
	swc_frame_t  frame;

	swc_spi_slave u_spi (
		.clk_in          (clk_in),
		.resetn_in       (resetn_in),
		.ce_in           (ce_in),
		.sclk_in         (sclk_in),
		.csn_in          (csn_in),
		.mosi_in         (mosi_in),
		.miso_out        (miso_out),
		.miso_oe_out     (miso_oe_out),
		.addr_out        (rd_addr),
		.rdata_in        (rd_data),
		.frame_valid_out (frame_valid),
		.frame_out       (frame)
	);

	// read selection; stored reserved bits are always zero
	wire        hit_wdog  = (rd_addr == `SWC_ADDR_WDOG);
	wire        hit_can   = (rd_addr == `SWC_ADDR_CAN_CH0_MODE_FIELD);
	wire        hit_iwake = (rd_addr == `SWC_ADDR_IWAKE);
	assign rd_data        = hit_wdog  ? wdog_r :
	                        hit_can   ? can_r :
	                        hit_iwake ? iwake_r : 8'h00;

	wire        wr        = frame_valid & frame.write;
	wire        wr_wdog   = wr & (frame.addr == `SWC_ADDR_WDOG);
	wire        wr_can    = wr & (frame.addr == `SWC_ADDR_CAN_CH0_MODE_FIELD);
	wire        wr_iwake  = wr & (frame.addr == `SWC_ADDR_IWAKE);

	// host write first, then device updates override the bits they own
	wire [7:0]  wdog_w    = wr_wdog ? (frame.data & `SWC_WDOG_WMASK) : wdog_r;
	wire [7:0]  can_w     = wr_can ? (frame.data & `SWC_CAN_CH0_MODE_FIELD_WMASK) : can_r;
	wire [7:0]  iwake_w   = wr_iwake ? (frame.data & `SWC_IWAKE_WMASK) : iwake_r;

	wire [1:0]  mode_lo   = can_w[1:0];
	wire        sleep_chg = sleep_entry_in & ((mode_lo == CAN_NORMAL
	                        & ~ch0_system_error_flag_in) | mode_lo == CAN_RX_ONLY);
	wire        fs_chg    = failsafe_entry_in & (mode_lo != CAN_WAKE);
	wire        lo_to_wake = sleep_chg | fs_chg;

	always_comb begin
		wdog_nxt  = wdog_w;
		can_nxt   = can_w;
		iwake_nxt = iwake_w;
		if (soft_reset_in) begin
			wdog_nxt  = `SWC_WDOG_RESET;
			can_nxt   = `SWC_CAN_CH0_MODE_FIELD_RESET;
			iwake_nxt = `SWC_IWAKE_RESET;
		end else if (restart_entry_in) begin
			wdog_nxt[`SWC_WD_STOP_OFF]      = 1'b0;
			wdog_nxt[`SWC_WD_PER_HI -: 3]   = `SWC_WD_PER_RESTART;
			can_nxt   = {5'h00, can_w[2:0]};
			iwake_nxt = iwake_w & `SWC_IWAKE_RST_KEEP;
		end else if (lo_to_wake) begin
			can_nxt   = {5'h00, can_w[`SWC_CAN_SELWAKE], `SWC_CAN_WAKE_LOW};
		end
	end

	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			wdog_r  <= `SWC_WDOG_RESET;
			can_r   <= `SWC_CAN_CH0_MODE_FIELD_RESET;
			iwake_r <= `SWC_IWAKE_RESET;
		end else if (ce_in) begin
			wdog_r  <= wdog_nxt;
			can_r   <= can_nxt;
			iwake_r <= iwake_nxt;
		end
	end

	// consecutive watchdog-failure reset limiter
	wire limit_on  = wdog_r[`SWC_WD_MAX3] & config_1_3_in;
	wire limit_hit = limit_on & (fail_cnt_r == `SWC_MAX_WDOG_RESETS);

	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			fail_cnt_r   <= 2'h0;
			reset_req_r  <= 1'b0;
			long_start_r <= 1'b0;
		end else if (ce_in) begin
			reset_req_r  <= wdog_fail_in & ~limit_hit;
			// a failure in the same cycle as a good trigger still counts
			if (wdog_fail_in) begin
				if (fail_cnt_r != `SWC_MAX_WDOG_RESETS)
					fail_cnt_r <= fail_cnt_r + 2'h1;
			end else if (wdog_trigger_ok_in) begin
				fail_cnt_r <= 2'h0;
			end
			long_start_r <= can_bus_wake_in & stop_mode_in
			                & wdog_r[`SWC_WD_BUS_START];
		end
	end

	always_comb begin
		unique case (wdog_r[`SWC_WD_PER_HI -: 3])
			3'h0:    period_ms = 10'h00a;
			3'h1:    period_ms = 10'h014;
			3'h2:    period_ms = 10'h032;
			3'h3:    period_ms = 10'h064;
			3'h4:    period_ms = 10'h0c8;
			3'h5:    period_ms = 10'h1f4;
			3'h7:    period_ms = 10'h3e8;
			default: period_ms = 10'h000;
		endcase
	end

	assign wdog_cfg_out.checksum_ok         = ~^wdog_r;
	assign wdog_cfg_out.window_type_select  = wdog_r[`SWC_WD_WINDOW];
	assign wdog_cfg_out.bus_wake_wdog_start = wdog_r[`SWC_WD_BUS_START];
	assign wdog_cfg_out.limit_resets        = wdog_r[`SWC_WD_MAX3];
	assign wdog_cfg_out.wdog_period_sel     = wdog_r[`SWC_WD_PER_HI -: 3];
	assign wdog_cfg_out.period_defined      = (wdog_r[`SWC_WD_PER_HI -: 3]
	                                           != `SWC_WD_PER_UNDEF);
	assign wdog_cfg_out.period_ms           = period_ms;
	assign wdog_cfg_out.stop_wdog_off       = wdog_r[`SWC_WD_STOP_OFF]
	                                          & iwake_r[`SWC_IW_STOP_OFF];

	assign wake_cfg_out.can_ch0_mode_field  = swc_can_mode_t'(can_r[1:0]);
	assign wake_cfg_out.selective_wake      = can_r[`SWC_CAN_SELWAKE];
	assign wake_cfg_out.cyclic_wake_enable  = iwake_r[`SWC_IW_CYCLIC];
	assign wake_cfg_out.batt_monitor_threshold = iwake_r[`SWC_IW_THR_HI:`SWC_IW_THR_LO];
	assign wake_cfg_out.fast_batt_monitor_enable = iwake_r[`SWC_IW_FAST_BATT];

	assign wdog_reset_req_out         = reset_req_r;
	assign wdog_long_window_start_out = long_start_r;

	// stop entry leaves the can field alone, so receive only must be set before
	wire stop_keeps = stop_entry_in & ~sleep_entry_in & ~restart_entry_in
	                  & ~soft_reset_in & ~failsafe_entry_in & ~wr_can;

	a_reserved_zero: assert property (@(posedge clk_in) disable iff (!resetn_in)
		can_r[7:3] == 5'h00 && iwake_r[7] == 1'b0 && iwake_r[3] == 1'b0
		&& iwake_r[1] == 1'b0)
		else $error("reserved bit set");

	a_soft_reset_vals: assert property (@(posedge clk_in) disable iff (!resetn_in)
		ce_in && soft_reset_in |=> wdog_r == 8'h14 && can_r == 8'h00
		&& iwake_r == 8'h01)
		else $error("soft reset values wrong");

	a_restart_wdog: assert property (@(posedge clk_in) disable iff (!resetn_in)
		ce_in && restart_entry_in && !soft_reset_in && !wr_wdog |=>
		wdog_r[6] == 1'b0 && wdog_r[2:0] == 3'h4
		&& wdog_r[7] == $past(wdog_r[7]) && wdog_r[5:3] == $past(wdog_r[5:3]))
		else $error("restart watchdog update wrong");

	a_restart_iwake: assert property (@(posedge clk_in) disable iff (!resetn_in)
		ce_in && restart_entry_in && !soft_reset_in && !wr_iwake |=>
		iwake_r == ($past(iwake_r) & 8'h71))
		else $error("restart internal wake update wrong");

	a_selwake_kept: assert property (@(posedge clk_in) disable iff (!resetn_in)
		ce_in && !soft_reset_in && !wr_can |=> can_r[2] == $past(can_r[2]))
		else $error("device changed selective wake bit");

	a_sleep_to_wake: assert property (@(posedge clk_in) disable iff (!resetn_in)
		ce_in && sleep_entry_in && !soft_reset_in && !restart_entry_in && !wr_can
		&& !ch0_system_error_flag_in && can_r[1] |=> can_r[1:0] == 2'h1)
		else $error("sleep entry did not go wake capable");

	a_stop_keeps: assert property (@(posedge clk_in) disable iff (!resetn_in)
		ce_in && stop_keeps |=> can_r == $past(can_r))
		else $error("stop entry changed can mode");

	a_failsafe_wake: assert property (@(posedge clk_in) disable iff (!resetn_in)
		ce_in && failsafe_entry_in && !soft_reset_in && !restart_entry_in
		|=> can_r[1:0] == 2'h1)
		else $error("fail-safe left channel unable to wake");

	a_stop_off_and: assert property (@(posedge clk_in) disable iff (!resetn_in)
		wdog_cfg_out.stop_wdog_off == (wdog_r[6] && iwake_r[2]))
		else $error("stop deactivation not both bits");

	a_reset_limit: assert property (@(posedge clk_in) disable iff (!resetn_in)
		ce_in && wdog_fail_in && limit_on && fail_cnt_r == 2'h3 |=> !wdog_reset_req_out)
		else $error("fourth watchdog reset not suppressed");

	a_reset_unlimited: assert property (@(posedge clk_in) disable iff (!resetn_in)
		ce_in && wdog_fail_in && !limit_on |=> wdog_reset_req_out)
		else $error("watchdog fail gave no reset");

	a_long_window: assert property (@(posedge clk_in) disable iff (!resetn_in)
		ce_in && can_bus_wake_in && stop_mode_in |=>
		wdog_long_window_start_out == $past(wdog_r[4]))
		else $error("bus wake start wrong");

	a_period_map: assert property (@(posedge clk_in) disable iff (!resetn_in)
		wdog_r[2:0] == 3'h7 |-> period_ms == 10'h3e8 && wdog_cfg_out.period_defined)
		else $error("period decode wrong");

	a_period_undef: assert property (@(posedge clk_in) disable iff (!resetn_in)
		wdog_r[2:0] == 3'h6 |->
		!wdog_cfg_out.period_defined && period_ms == 10'h000)
		else $error("undefined period shown as defined");

	a_period_short: assert property (@(posedge clk_in) disable iff (!resetn_in)
		wdog_r[2:0] == 3'h0 |->
		period_ms == 10'h00a && wdog_cfg_out.period_defined)
		else $error("shortest period decode wrong");

	a_host_wdog_write: assert property (@(posedge clk_in) disable iff (!resetn_in)
		ce_in && wr_wdog && !soft_reset_in && !restart_entry_in
		|=> wdog_r == $past(frame.data))
		else $error("watchdog write did not land");

	a_host_can_write: assert property (@(posedge clk_in) disable iff (!resetn_in)
		ce_in && wr_can && !soft_reset_in && !restart_entry_in && !sleep_entry_in
		&& !failsafe_entry_in |=> can_r == {5'h00, $past(frame.data[2:0])})
		else $error("can mode write did not land");

	a_host_iwake_write: assert property (@(posedge clk_in) disable iff (!resetn_in)
		ce_in && wr_iwake && !soft_reset_in && !restart_entry_in
		|=> iwake_r == ($past(frame.data) & 8'h75))
		else $error("internal wake write did not land");

	a_restart_can: assert property (@(posedge clk_in) disable iff (!resetn_in)
		ce_in && restart_entry_in && !soft_reset_in && !wr_can
		|=> can_r == $past(can_r))
		else $error("restart changed can mode bits");

	a_sleep_err_keep: assert property (@(posedge clk_in) disable iff (!resetn_in)
		ce_in && sleep_entry_in && !soft_reset_in && !restart_entry_in && !wr_can
		&& !failsafe_entry_in && ch0_system_error_flag_in && can_r[1:0] == 2'h3
		|=> can_r == $past(can_r))
		else $error("normal mode left despite system error");

	a_sleep_rx_wake: assert property (@(posedge clk_in) disable iff (!resetn_in)
		ce_in && sleep_entry_in && !soft_reset_in && !restart_entry_in && !wr_can
		&& can_r[1:0] == 2'h2 |=> can_r[1:0] == 2'h1)
		else $error("receive only kept on sleep entry");

	a_wake_off_kept: assert property (@(posedge clk_in) disable iff (!resetn_in)
		ce_in && (sleep_entry_in || stop_entry_in) && !soft_reset_in && !restart_entry_in
		&& !failsafe_entry_in && !wr_can && !can_r[1] |=> can_r == $past(can_r))
		else $error("wake capable or off mode changed");

	a_iwake_hold: assert property (@(posedge clk_in) disable iff (!resetn_in)
		ce_in && !wr_iwake && !soft_reset_in && !restart_entry_in
		|=> iwake_r == $past(iwake_r))
		else $error("internal wake changed without cause");

	a_wdog_hold: assert property (@(posedge clk_in) disable iff (!resetn_in)
		ce_in && !wr_wdog && !soft_reset_in && !restart_entry_in
		|=> wdog_r == $past(wdog_r))
		else $error("watchdog config changed without cause");

	a_fail_counted: assert property (@(posedge clk_in) disable iff (!resetn_in)
		ce_in && wdog_fail_in |=> fail_cnt_r != 2'h0)
		else $error("watchdog failure not counted");

	a_fail_cleared: assert property (@(posedge clk_in) disable iff (!resetn_in)
		ce_in && wdog_trigger_ok_in && !wdog_fail_in |=> fail_cnt_r == 2'h0)
		else $error("good trigger did not clear count");

	a_no_wake_start: assert property (@(posedge clk_in) disable iff (!resetn_in)
		ce_in && !(can_bus_wake_in && stop_mode_in) |=> !wdog_long_window_start_out)
		else $error("long window start without bus wake");

	a_reserved_read: assert property (@(posedge clk_in) disable iff (!resetn_in)
		!hit_wdog && !hit_can && !hit_iwake |-> rd_data == 8'h00)
		else $error("unmapped address read not zero");

	c_host_write: cover property (@(posedge clk_in) disable iff (!resetn_in)
		wr_wdog);
	c_sleep_auto: cover property (@(posedge clk_in) disable iff (!resetn_in)
		sleep_chg ##1 can_r[1:0] == 2'h1);
	c_restart: cover property (@(posedge clk_in) disable iff (!resetn_in)
		restart_entry_in && ce_in);
	c_limit: cover property (@(posedge clk_in) disable iff (!resetn_in)
		limit_hit && wdog_fail_in);
	c_failsafe: cover property (@(posedge clk_in) disable iff (!resetn_in)
		failsafe_entry_in && ce_in);

endmodule // swc_config_bank

// ==== swc_host_model.sv ====
/*
 * host model: serial master for the configuration bank, mode 0, msb first.
 * assumes the bench calls xfer and that clk_in is the bank's 25 MHz clock.
 */
`timescale 1ns/10ps

module swc_host_model (
	input  wire logic clk_in,
	input  wire logic miso_in,
	output logic      sclk_out,
	output logic      csn_out,
	output logic      mosi_out
);
	initial begin
		sclk_out = 1'b0;
		csn_out  = 1'b1;
		mosi_out = 1'b0;
	end

	// one 16-bit frame, sclk high for 5 clocks and low for 6; second byte returned in rd
	task automatic xfer(input logic [15:0] w, output logic [7:0] rd);
		int i;
		rd = 8'h00;
		@(negedge clk_in) csn_out = 1'b0;
		for (i = 15; i >= 0; i--) begin
			@(negedge clk_in) mosi_out = w[i];
			repeat (5) @(negedge clk_in);
			if (i < 8)
				rd[i] = miso_in;
			sclk_out = 1'b1;
			repeat (5) @(negedge clk_in);
			sclk_out = 1'b0;
		end
		repeat (5) @(negedge clk_in);
		csn_out = 1'b1;
		// released data line must not keep the last bit
		mosi_out = ~mosi_out;
		repeat (6) @(negedge clk_in);
	endtask
endmodule // swc_host_model

// ==== tb_top.sv ====
/*
 * self-checking bench for the configuration bank: serial accesses and events.
 * assumes swc_pkg is compiled first and swc_regs.svh is on the include path.
 */
`timescale 1ns/10ps
`include "swc_regs.svh"

module tb_top
	import swc_pkg::*;
;
	logic          clk_in    = 1'b0;
	logic          resetn_in = 1'b0;
	logic [7:0]    ev        = 8'h00;
	logic          ce        = 1'b1;
	logic          stop_mode;
	logic          syserr;
	logic          cfg13;
	logic          sclk;
	logic          csn;
	logic          mosi;
	logic          miso;
	logic          miso_oe;
	logic          rst_req;
	logic          long_win;
	swc_wdog_cfg_t wcfg;
	swc_wake_cfg_t kcfg;
	int            miscompares = 0;
	int            checks      = 0;
	int            i;
	int            k;
	int            per [8] = '{10, 20, 50, 100, 200, 500, 0, 1000};

	always #20 clk_in = ~clk_in;

	swc_host_model host_u (
		.clk_in   (clk_in),
		.miso_in  (miso),
		.sclk_out (sclk),
		.csn_out  (csn),
		.mosi_out (mosi)
	);

	swc_config_bank dut_u (
		.clk_in                     (clk_in),
		.resetn_in                  (resetn_in),
		.ce_in                      (ce),
		.sclk_in                    (sclk),
		.csn_in                     (csn),
		.mosi_in                    (mosi),
		.miso_out                   (miso),
		.miso_oe_out                (miso_oe),
		.soft_reset_in              (ev[0]),
		.restart_entry_in           (ev[1]),
		.failsafe_entry_in          (ev[2]),
		.sleep_entry_in             (ev[3]),
		.stop_entry_in              (ev[4]),
		.stop_mode_in               (stop_mode),
		.ch0_system_error_flag_in   (syserr),
		.can_bus_wake_in            (ev[5]),
		.wdog_fail_in               (ev[6]),
		.wdog_trigger_ok_in         (ev[7]),
		.config_1_3_in              (cfg13),
		.wdog_reset_req_out         (rst_req),
		.wdog_long_window_start_out (long_win),
		.wdog_cfg_out               (wcfg),
		.wake_cfg_out               (kcfg)
	);

	task automatic end_sim;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		checks++;
		if (g !== e) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic rd(input logic [6:0] a, input logic [7:0] e);
		logic [7:0] r;
		host_u.xfer({1'b0, a, 8'h00}, r);
		chk($sformatf("reg %h", a), {8'h00, e}, {8'h00, r});
	endtask

	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		logic [7:0] r;
		host_u.xfer({1'b1, a, d}, r);
	endtask

	task automatic pulse(input int n);
		@(negedge clk_in) ev[n] = 1'b1;
		@(negedge clk_in) ev = 8'h00;
	endtask

	task automatic fchk(input logic e);
		pulse(6);
		chk("reset_req", {15'h0, e}, {15'h0, rst_req});
	endtask

	task automatic tend(input string n);
		$display("test %s done", n);
	endtask

	// top bit makes the byte even parity
	function automatic logic [7:0] wd(input logic [6:0] b);
		return {^b, b};
	endfunction

	// e: 0 sleep without error, 1 sleep with error, 2 stop
	function automatic logic [7:0] can_exp(input logic [2:0] c, input int e);
		logic [2:0] r;
		r = c;
		if ((e == 0 && c[1]) || (e == 1 && c[1:0] == 2'b10))
			r[1:0] = `SWC_CAN_WAKE_LOW;
		return {5'h00, r};
	endfunction

	initial begin
		repeat (100000) @(posedge clk_in);
		miscompares++;
		$display("BAD run_length expected %h seen %h", 1'b0, 1'b1);
		end_sim;
	end

	initial begin
		stop_mode = 1'b0;
		syserr    = 1'b0;
		cfg13     = 1'b0;
		repeat (8) @(negedge clk_in);
		resetn_in = 1'b1;
		repeat (4) @(negedge clk_in);
		rd(`SWC_ADDR_WDOG, `SWC_WDOG_RESET);
		rd(`SWC_ADDR_CAN_CH0_MODE_FIELD, `SWC_CAN_CH0_MODE_FIELD_RESET);
		rd(`SWC_ADDR_IWAKE, `SWC_IWAKE_RESET);
		chk("miso_oe", 16'h0, {15'h0, miso_oe});
		tend("reset");
		wr(`SWC_ADDR_CAN_CH0_MODE_FIELD, 8'hff);
		rd(`SWC_ADDR_CAN_CH0_MODE_FIELD, 8'h07);
		wr(`SWC_ADDR_IWAKE, 8'hff);
		rd(`SWC_ADDR_IWAKE, 8'h75);
		chk("cyclic", 16'h1, 16'(kcfg.cyclic_wake_enable));
		chk("threshold", 16'h3, 16'(kcfg.batt_monitor_threshold));
		chk("fast_batt", 16'h1, 16'(kcfg.fast_batt_monitor_enable));
		wr(7'h05, 8'h5a);
		rd(7'h05, 8'h00);
		tend("reserved");
		for (i = 0; i < 8; i++) begin
			wr(`SWC_ADDR_WDOG, wd({4'h0, i[2:0]}));
			chk("period", 16'(per[i]), 16'(wcfg.period_ms));
			chk("period_sel", 16'(i[2:0]), 16'(wcfg.wdog_period_sel));
			chk("defined", {15'h0, i != 6}, 16'(wcfg.period_defined));
		end
		wr(`SWC_ADDR_WDOG, wd(7'h78));
		chk("window", 16'h1, 16'(wcfg.window_type_select));
		chk("bus_start", 16'h1, 16'(wcfg.bus_wake_wdog_start));
		chk("limit", 16'h1, 16'(wcfg.limit_resets));
		chk("stop_off", 16'h1, 16'(wcfg.stop_wdog_off));
		chk("checksum", 16'h1, 16'(wcfg.checksum_ok));
		wr(`SWC_ADDR_IWAKE, 8'h71);
		chk("stop_off", 16'h0, 16'(wcfg.stop_wdog_off));
		wr(`SWC_ADDR_WDOG, 8'hf8);
		chk("checksum", 16'h0, 16'(wcfg.checksum_ok));
		tend("watchdog_bits");
		cfg13 = 1'b1;
		for (i = 0; i < 4; i++)
			fchk(i < 3);
		pulse(7);
		fchk(1'b1);
		cfg13 = 1'b0;
		for (i = 0; i < 4; i++)
			fchk(1'b1);
		cfg13 = 1'b1;
		fchk(1'b0);
		wr(`SWC_ADDR_WDOG, wd(7'h70));
		fchk(1'b1);
		tend("reset_limit");
		stop_mode = 1'b1;
		pulse(5);
		chk("long_window", 16'h1, {15'h0, long_win});
		wr(`SWC_ADDR_WDOG, wd(7'h60));
		pulse(5);
		chk("long_window", 16'h0, {15'h0, long_win});
		stop_mode = 1'b0;
		tend("bus_wake");
		wr(`SWC_ADDR_WDOG, wd(7'h7f));
		wr(`SWC_ADDR_CAN_CH0_MODE_FIELD, 8'h07);
		wr(`SWC_ADDR_IWAKE, 8'h75);
		// a restart while the clock enable is low must leave the watchdog config as it was
		ce = 1'b0;
		pulse(1);
		ce = 1'b1;
		rd(`SWC_ADDR_WDOG, 8'hff);
		pulse(1);
		rd(`SWC_ADDR_WDOG, 8'hbc);
		rd(`SWC_ADDR_CAN_CH0_MODE_FIELD, 8'h07);
		rd(`SWC_ADDR_IWAKE, 8'h75 & `SWC_IWAKE_RST_KEEP);
		pulse(0);
		rd(`SWC_ADDR_WDOG, `SWC_WDOG_RESET);
		rd(`SWC_ADDR_CAN_CH0_MODE_FIELD, `SWC_CAN_CH0_MODE_FIELD_RESET);
		rd(`SWC_ADDR_IWAKE, `SWC_IWAKE_RESET);
		tend("restart_soft_reset");
		wr(`SWC_ADDR_CAN_CH0_MODE_FIELD, 8'h07);
		pulse(2);
		rd(`SWC_ADDR_CAN_CH0_MODE_FIELD, 8'h05);
		tend("fail_safe");
		for (k = 0; k < 3; k++) begin
			for (i = 0; i < 8; i++) begin
				wr(`SWC_ADDR_CAN_CH0_MODE_FIELD, {5'h00, i[2:0]});
				chk("mode", 16'(i[1:0]), 16'(kcfg.can_ch0_mode_field));
				chk("selwake", 16'(i[2]), 16'(kcfg.selective_wake));
				syserr = (k == 1);
				pulse(k == 2 ? 4 : 3);
				rd(`SWC_ADDR_CAN_CH0_MODE_FIELD, can_exp(i[2:0], k));
			end
		end
		syserr = 1'b0;
		tend("can_modes");
		end_sim;
	end
endmodule // tb_top
